// [hw/sprw_ctl.sv]
// Functional notes
// - two-bit suspend state selector, states zero-three
// - selector resets and unconfigured entry force two
// - states zero and one behave identically
// - writing one starts ethernet phy reset
// - phy held in reset at least 4 ms
// - request bit self-clears when phy released
// - writes ignored while request bit high and until the phy reports up
// - ready drops on request, returns when operational
// - hold may extend to 128 ms
// - lan wake enable, default zero
// - lan wake enable cleared after remote resume
// - phy interrupt wake enable, default zero
// - phy wake enable cleared after remote resume
// - resume-clear control defaults one, remote resumes only
module sprw_ctl
  import sprw_pkg::*;
#(
  parameter int unsigned HOLD_MIN_CYC  = SPRW_HOLD_MIN_CYC,
  parameter int unsigned HOLD_LONG_CYC = SPRW_HOLD_LONG_CYC
)
(
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire sprw_wr_t wr,
  input  wire logic     unconfigured_entry,
  input  wire logic     resume_done,
  input  wire logic     resume_remote,
  input  wire logic     skip_analog_reference_wait,
  input  wire logic     phy_operational,
  input  wire logic     other_ready,
  output sprw_rd_t      rd,
  output logic          phy_reset_out,
  output logic          lan_wake_event_en,
  output logic          phy_interrupt_event_en,
  output sprw_susp_t    suspend_state_eff
);

  // software-visible configuration
  sprw_susp_t             susp_r,      susp_nxt;
  logic                   lan_wake_r,  lan_wake_nxt;
  logic                   phy_wake_r,  phy_wake_nxt;
  logic                   res_clr_r,   res_clr_nxt;
  // phy reset sequencer and device-ready
  logic                   ready_r,     ready_nxt;
  logic                   prst_out_r,  prst_out_nxt;
  sprw_phy_st_t           st_r,        st_nxt;
  logic [SPRW_CNT_W-1:0]  cnt_r,       cnt_nxt;
  // resume-completion clear strobe
  logic                   remote_clr;

  // phy counts as up only once the other ready sources agree too
  function automatic logic sprw_phy_up
  (
    input logic op,
    input logic oth
  );
    sprw_phy_up = op & oth;
  endfunction

  // a reset request is a strobed write of one; a written zero does nothing
  function automatic logic sprw_req_one
  (
    input sprw_wr_t w
  );
    sprw_req_one = w.ethernet_phy_reset_request_we & w.ethernet_phy_reset_request_wd;
  endfunction

  // hold counter load; the count runs down to zero inclusive, hence minus one
  function automatic logic [SPRW_CNT_W-1:0] sprw_hold_load
  (
    input logic skip
  );
    // reference kept alive: the phy may leave reset after the minimum
    if (skip)
      sprw_hold_load = SPRW_CNT_W'(HOLD_MIN_CYC - 1);
    else
      sprw_hold_load = SPRW_CNT_W'(HOLD_LONG_CYC - 1);
  endfunction

  // wake enables only cleared by remote-wake resumes
  // host resumes leave the enables alone
  assign remote_clr = resume_done && resume_remote && res_clr_r;

  // configuration bits next values
  always_comb
  begin
    susp_nxt     = susp_r;
    lan_wake_nxt = lan_wake_r;
    phy_wake_nxt = phy_wake_r;
    res_clr_nxt  = res_clr_r;
    if (wr.susp_we)
      susp_nxt = wr.susp_wd;
    // falling to unconfigured wins over a same-cycle write
    if (unconfigured_entry)
      susp_nxt = SPRW_SUSP_RST;
    // software writes to the wake enables
    if (wr.lan_wake_we)
      lan_wake_nxt = wr.lan_wake_wd;
    if (wr.phy_wake_we)
      phy_wake_nxt = wr.phy_wake_wd;
    // auto clear outranks software write at resume completion
    if (remote_clr)
    begin
      lan_wake_nxt = 1'b0;
      phy_wake_nxt = 1'b0;
    end
    // resume-clear control is a plain software bit
    if (wr.res_clr_we)
      res_clr_nxt = wr.res_clr_wd;
  end

  // configuration registers with their reset values
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      susp_r     <= SPRW_SUSP_RST;
      lan_wake_r <= SPRW_LAN_WAKE_RST;
      phy_wake_r <= SPRW_PHY_WAKE_RST;
      res_clr_r  <= SPRW_RES_CLR_RST;
    end
    else
    begin
      susp_r     <= susp_nxt;
      lan_wake_r <= lan_wake_nxt;
      phy_wake_r <= phy_wake_nxt;
      res_clr_r  <= res_clr_nxt;
    end
  end

  // phy reset sequencer: hold counts down, then wait for phy operational
  always_comb
  begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    prst_out_nxt = prst_out_r;
    ready_nxt    = ready_r;
    unique case (st_r)
      SPRW_PHY_IDLE:
      begin
        // writes only reach here while request reads low
        if (sprw_req_one(wr))
        begin
          st_nxt       = SPRW_PHY_HOLD;
          prst_out_nxt = 1'b1;
          ready_nxt    = 1'b0;
          // skip is sampled once here; later changes do not stretch the hold
          cnt_nxt = sprw_hold_load(skip_analog_reference_wait);
        end
        else
        begin
          // first rise after reset: no request, phy merely has to come up
          ready_nxt = ready_r | sprw_phy_up(phy_operational, other_ready);
        end
      end
      SPRW_PHY_HOLD:
      begin
        // counter reaches zero on the last held cycle
        // writes to the request bit are ignored in this state
        if (cnt_r == '0)
        begin
          st_nxt       = SPRW_PHY_SETTLE;
          prst_out_nxt = 1'b0;
        end
        else
          cnt_nxt = cnt_r - SPRW_CNT_W'(1);
      end
      SPRW_PHY_SETTLE:
      begin
        // requests stay refused until the phy reports up; a second reset
        // here would only restart a phy that has not yet come up
        if (sprw_phy_up(phy_operational, other_ready))
        begin
          st_nxt    = SPRW_PHY_IDLE;
          ready_nxt = 1'b1;
        end
      end
      default:
      begin
        // unused code: release the phy and fall back to idle
        st_nxt       = SPRW_PHY_IDLE;
        prst_out_nxt = 1'b0;
      end
    endcase
  end

  // sequencer registers; counter cleared so no stale count survives reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r       <= SPRW_PHY_IDLE;
      cnt_r      <= '0;
      prst_out_r <= SPRW_ETHERNET_PHY_RESET_REQUEST_RST;
      ready_r    <= SPRW_READY_RST;
    end
    else
    begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      prst_out_r <= prst_out_nxt;
      ready_r    <= ready_nxt;
    end
  end

  // states zero and one collapse to one behaviour downstream
  assign suspend_state_eff = (susp_r == SPRW_LOW_POWER_STATE_ONE) ?
                             SPRW_LOW_POWER_STATE_ZERO : susp_r;

  // drive and enables straight from flops, no glitches toward the phy
  assign phy_reset_out          = prst_out_r;
  assign lan_wake_event_en      = lan_wake_r;
  assign phy_interrupt_event_en = phy_wake_r;

  // readback: request bit mirrors the phy reset drive
  assign rd.susp        = susp_r;
  assign rd.ethernet_phy_reset_request_req = prst_out_r;
  assign rd.lan_wake_en = lan_wake_r;
  assign rd.phy_interrupt_wake_enable = phy_wake_r;
  assign rd.res_clr_en  = res_clr_r;
  assign rd.dev_ready   = ready_r;

endmodule // sprw_ctl

// [hw/sprw_pkg.sv]
package sprw_pkg;

  // suspend state selector codes
  typedef enum logic [1:0]
  {
    SPRW_LOW_POWER_STATE_ZERO  = 2'h0,
    SPRW_LOW_POWER_STATE_ONE   = 2'h1,
    SPRW_LOW_POWER_STATE_TWO   = 2'h2,
    SPRW_LOW_POWER_STATE_THREE = 2'h3
  } sprw_susp_t;

  // phy reset sequencer states
  typedef enum logic [1:0]
  {
    SPRW_PHY_IDLE  = 2'h0,
    SPRW_PHY_HOLD  = 2'h1,
    SPRW_PHY_SETTLE = 2'h2
  } sprw_phy_st_t;

  // software write bundle: strobe plus data for each field
  typedef struct packed
  {
    logic       susp_we;
    sprw_susp_t susp_wd;
    logic       ethernet_phy_reset_request_we;
    logic       ethernet_phy_reset_request_wd;
    logic       lan_wake_we;
    logic       lan_wake_wd;
    logic       phy_wake_we;
    logic       phy_wake_wd;
    logic       res_clr_we;
    logic       res_clr_wd;
  } sprw_wr_t;

  // readable state of the block
  typedef struct packed
  {
    sprw_susp_t susp;
    logic       ethernet_phy_reset_request_req;
    logic       lan_wake_en;
    logic       phy_interrupt_wake_enable;
    logic       res_clr_en;
    logic       dev_ready;
  } sprw_rd_t;

  localparam sprw_susp_t SPRW_SUSP_RST      = SPRW_LOW_POWER_STATE_TWO;
  localparam logic       SPRW_ETHERNET_PHY_RESET_REQUEST_RST   = 1'b0;
  localparam logic       SPRW_LAN_WAKE_RST  = 1'b0;
  localparam logic       SPRW_PHY_WAKE_RST  = 1'b0;
  localparam logic       SPRW_RES_CLR_RST   = 1'b1;
  localparam logic       SPRW_READY_RST     = 1'b0;

  // timing: clock rate and hold times
  localparam int unsigned SPRW_CLK_MHZ       = 125;
  localparam int unsigned SPRW_HOLD_MIN_MS   = 4;
  localparam int unsigned SPRW_HOLD_LONG_MS  = 128;
  localparam int unsigned SPRW_HOLD_MIN_CYC  = SPRW_HOLD_MIN_MS * 1000 * SPRW_CLK_MHZ;
  localparam int unsigned SPRW_HOLD_LONG_CYC = SPRW_HOLD_LONG_MS * 1000 * SPRW_CLK_MHZ;
  localparam int unsigned SPRW_CNT_W         = 24;

endpackage : sprw_pkg

// [verif/sprw_ctl_sva.sv]
module sprw_chk
  import sprw_pkg::*;
#(
  parameter int unsigned HOLD_MIN_CYC  = 8,
  parameter int unsigned HOLD_LONG_CYC = 32
)
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire sprw_wr_t   wr,
  input wire logic       unconfigured_entry,
  input wire logic       resume_done,
  input wire logic       resume_remote,
  input wire logic       skip_analog_reference_wait,
  input wire logic       phy_operational,
  input wire logic       other_ready,
  input wire sprw_rd_t   rd,
  input wire logic       phy_reset_out,
  input wire sprw_susp_t suspend_state_eff
);
  timeunit 1ns / 1ps;
  logic [23:0] cnt_r, cnt_nxt, lim_r, lim_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // hold length latched while idle, since skip is only sampled at request
  always_comb
  begin
    cnt_nxt = phy_reset_out ? cnt_r + 24'h1 : 24'h0;
    lim_nxt = phy_reset_out ? lim_r :
              24'(skip_analog_reference_wait ? HOLD_MIN_CYC : HOLD_LONG_CYC);
  end
  always_ff @(posedge clk)
  begin
    cnt_r <= sys_rst ? 24'h0 : cnt_nxt;
    lim_r <= lim_nxt;
  end
  AST_HOLD_LEN: assert property ($fell(phy_reset_out) |-> cnt_r == lim_r)
    else $error("hold");
  AST_HOLD_MAX: assert property (phy_reset_out |-> cnt_r < lim_r) else $error("overhold");
  AST_DRIVE: assert property (phy_reset_out == rd.ethernet_phy_reset_request_req) else $error("drive");
  AST_START: assert property (wr.ethernet_phy_reset_request_we && wr.ethernet_phy_reset_request_wd && rd.dev_ready
    |=> phy_reset_out && !rd.dev_ready) else $error("start");
  AST_NOT_RDY: assert property (phy_reset_out |-> !rd.dev_ready) else $error("rdy");
  AST_RDY_BACK: assert property (!phy_reset_out && phy_operational && other_ready
    && !wr.ethernet_phy_reset_request_we |=> rd.dev_ready) else $error("rdy back");
  AST_SUSP_WR: assert property (wr.susp_we && !unconfigured_entry
    |=> rd.susp == $past(wr.susp_wd)) else $error("susp");
  AST_UNCONF: assert property (unconfigured_entry |=> rd.susp == SPRW_LOW_POWER_STATE_TWO)
    else $error("unconf");
  AST_EFF: assert property (suspend_state_eff == (rd.susp == SPRW_LOW_POWER_STATE_ONE ?
    SPRW_LOW_POWER_STATE_ZERO : rd.susp)) else $error("eff");
  AST_WAKE_CLR: assert property (resume_done && resume_remote && rd.res_clr_en
    |=> !rd.lan_wake_en && !rd.phy_interrupt_wake_enable) else $error("clr");
  AST_HOST_RES: assert property (resume_done && !resume_remote && !wr.lan_wake_we
    |=> $stable(rd.lan_wake_en)) else $error("host");
  cover property ($fell(phy_reset_out) && lim_r == 24'(HOLD_LONG_CYC));
  cover property (resume_done && resume_remote && rd.res_clr_en);
  cover property (unconfigured_entry);
endmodule // sprw_chk

bind sprw_ctl sprw_chk #(.HOLD_MIN_CYC(HOLD_MIN_CYC), .HOLD_LONG_CYC(HOLD_LONG_CYC)) u_chk
  (.clk, .sys_rst, .wr, .unconfigured_entry, .resume_done, .resume_remote,
   .skip_analog_reference_wait, .phy_operational, .other_ready, .rd, .phy_reset_out,
   .suspend_state_eff);

// [verif/sprw_phy_model.sv]
module sprw_phy_model #(parameter int unsigned SETTLE_CYC = 5)
(
  input  wire logic clk,
  input  wire logic phy_reset_out,
  output logic      phy_operational
);
  timeunit 1ns / 1ps;
  logic [7:0] cnt_r = 8'h0;
  // phy is not operational until a settle time after reset release;
  // an unknown drive before the first reset edge counts as reset
  always_ff @(posedge clk)
  begin
    cnt_r <= (phy_reset_out !== 1'b0) ? 8'h0 : cnt_r + 8'(cnt_r != 8'(SETTLE_CYC));
  end
  assign phy_operational = cnt_r == 8'(SETTLE_CYC);
endmodule // sprw_phy_model

// [verif/test_suspend_phy_reset_wake_ctl.sv]
module test_suspend_phy_reset_wake_ctl;
  import sprw_pkg::*;
  timeunit 1ns / 1ps;
  logic       clk = 0, sys_rst = 1, unconfigured_entry = 0, resume_done = 0, resume_remote = 0;
  logic       skip = 1, other_ready = 1, phy_operational, phy_reset_out;
  logic       lan_ev, phy_ev;
  sprw_wr_t   wr = '0;
  sprw_rd_t   rd;
  sprw_susp_t eff;
  int         error_cnt = 0, cmp_count = 0, n;
  always #4 clk = ~clk;
  sprw_ctl #(.HOLD_MIN_CYC(8), .HOLD_LONG_CYC(32)) u_dut (.clk, .sys_rst, .wr,
    .unconfigured_entry, .resume_done, .resume_remote, .skip_analog_reference_wait(skip),
    .phy_operational, .other_ready, .rd, .phy_reset_out, .lan_wake_event_en(lan_ev),
    .phy_interrupt_event_en(phy_ev), .suspend_state_eff(eff));
  sprw_phy_model u_phy (.clk, .phy_reset_out, .phy_operational);
  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe then an idle cycle, entered at a falling edge
  task automatic put(input logic [10:0] w);
    wr = sprw_wr_t'(w);
    @(negedge clk);
    wr = '0;
    @(negedge clk);
  endtask
  task automatic res(input logic rm);
    resume_remote = rm;
    resume_done = 1;
    @(negedge clk);
    resume_done = 0;
    @(negedge clk);
  endtask
  task automatic wait_rdy;
    for (n = 0; rd.dev_ready !== 1'b1 && n < 100; n++)
      @(negedge clk);
    chk("ready", 8'h1, rd.dev_ready);
    if (n == 100) report_and_stop();
  endtask
  // rewrites during the hold must neither restart nor cut it short
  task automatic ethernet_phy_reset_request(input logic sk, input logic [7:0] len);
    skip = sk;
    put(11'h0c0);
    chk("phy reset", 8'h1, phy_reset_out);
    chk("ready low", 8'h0, rd.dev_ready);
    // n starts at one: the first held cycle already passed inside put
    for (n = 1; phy_reset_out === 1'b1 && n < 100; n++)
    begin
      wr = sprw_wr_t'(n == 1 ? 11'h0c0 : 11'h080);
      @(negedge clk);
    end
    wr = '0;
    chk("hold", len, 8'(n));
    if (n == 100) report_and_stop();
    wait_rdy();
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    chk("defaults", 8'h21, rd[6:1]);
    for (int c = 0; c < 4; c++)
    begin
      put({1'b1, 2'(c), 8'h00});
      chk("susp", 8'(c), rd.susp);
      chk("eff", c == 1 ? 8'h0 : 8'(c), eff);
    end
    unconfigured_entry = 1;
    @(negedge clk);
    unconfigured_entry = 0;
    chk("unconf", 8'h2, rd.susp);
    put({1'b1, 2'h2, 8'h00});
    chk("unconf write", 8'h2, rd.susp);
    wait_rdy();
    ethernet_phy_reset_request(1'b1, 8'h08);
    put(11'h03c);
    res(1'b0);
    chk("host resume", 8'h3, rd[3:2]);
    chk("host events", 8'h3, {lan_ev, phy_ev});
    res(1'b1);
    chk("remote resume", 8'h0, rd[3:2]);
    chk("remote events", 8'h0, {lan_ev, phy_ev});
    ethernet_phy_reset_request(1'b0, 8'h20);
    put(11'h03e);
    res(1'b1);
    chk("no clear", 8'h3, rd[3:2]);
    report_and_stop();
  end
endmodule // test_suspend_phy_reset_wake_ctl
